// ===== include/urs_defs.svh
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define URS_ADDR_0        3'h0
`define URS_ADDR_1        3'h1
`define URS_ADDR_2        3'h2
`define URS_ADDR_3        3'h3
`define URS_ADDR_4        3'h4
`define URS_ADDR_5        3'h5
`define URS_ADDR_6        3'h6
`define URS_ADDR_7        3'h7

// ----------------------------------------------------------------
// selection keys, field positions, reset values
// ----------------------------------------------------------------
`define URS_ENH_KEY       8'hbf
`define URS_ZERO_BYTE     8'h00
`define URS_RST_VAL       8'h00
`define URS_DIV_EN_BIT    7
`define URS_EXT_FEAT_BIT  4
`define URS_FEAT_SEL_BIT  6
`define URS_GPIO_ACC_BIT  0
`define URS_DEV_REV_VAL   8'h5a

// one bit per register code: stored in a flop / readable back
`define URS_STORE_MASK    32'h3ffbae9c
`define URS_READ_MASK     32'h3ff10c9c

`endif

// ===== include/urs_pkg.sv
package urs_pkg;

  // ----------------------------------------------------------------
  // register selection codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    URS_NONE       = 5'h00,
    URS_DEV_REV    = 5'h01,
    URS_DIV_LO     = 5'h02,
    URS_DIV_HI     = 5'h03,
    URS_DIV_FRAC   = 5'h04,
    URS_RX_HOLD    = 5'h05,
    URS_TX_HOLD    = 5'h06,
    URS_INT_EN     = 5'h07,
    URS_INT_STAT   = 5'h08,
    URS_FIFO_CTL   = 5'h09,
    URS_LINE_CTL   = 5'h0a,
    URS_MODEM_CTL  = 5'h0b,
    URS_LINE_STAT  = 5'h0c,
    URS_RS485      = 5'h0d,
    URS_MODEM_STAT = 5'h0e,
    URS_SPEC_FN    = 5'h0f,
    URS_SCRATCH    = 5'h10,
    URS_ENH_MODE   = 5'h11,
    URS_FIFO_LVL   = 5'h12,
    URS_TRIG_LVL   = 5'h13,
    URS_FEAT_CTL   = 5'h14,
    URS_ENH_FN     = 5'h15,
    URS_RESUME1    = 5'h16,
    URS_RESUME2    = 5'h17,
    URS_STOP1      = 5'h18,
    URS_STOP2      = 5'h19,
    URS_GPIO_INT   = 5'h1a,
    URS_GPIO_TRI   = 5'h1b,
    URS_GPIO_POL   = 5'h1c,
    URS_GPIO_SEL   = 5'h1d
  } urs_reg_type;

  typedef logic [7:0] urs_byte_type;

endpackage

// ===== include/urs_sel_if.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// selection handed from the decoder to the register core
// ----------------------------------------------------------------
interface urs_sel_if;
  urs_pkg::urs_reg_type rd_sel;
  urs_pkg::urs_reg_type wr_sel;
  modport dec  (output rd_sel, output wr_sel);
  modport core (input rd_sel, input wr_sel);
endinterface

// ===== verilog/urs_decode.sv
`timescale 1ns/1ps
`include "urs_defs.svh"

module urs_decode (
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_line_ctl,
  input  wire logic [7:0] i_div_lo,
  input  wire logic [7:0] i_div_hi,
  input  wire logic       i_ext_feat,
  input  wire logic       i_feat_sel,
  input  wire logic       i_gpio_acc,
  urs_sel_if.dec          sel
);

  // ----------------------------------------------------------------
  // mode terms
  // ----------------------------------------------------------------
  wire logic enh      = (i_line_ctl == `URS_ENH_KEY);
  wire logic div_bit  = i_line_ctl[`URS_DIV_EN_BIT];
  wire logic div_acc  = div_bit & ~enh;
  wire logic div_zero = (i_div_lo == `URS_ZERO_BYTE) & (i_div_hi == `URS_ZERO_BYTE);

  urs_pkg::urs_reg_type rd_tab [8];
  urs_pkg::urs_reg_type wr_tab [8];

  // enhanced page 4..7: flow characters or gpio block
  urs_pkg::urs_reg_type enh4, enh5, enh6, enh7;
  assign enh4 = i_gpio_acc ? urs_pkg::URS_GPIO_INT : urs_pkg::URS_RESUME1;
  assign enh5 = i_gpio_acc ? urs_pkg::URS_GPIO_TRI : urs_pkg::URS_RESUME2;
  assign enh6 = i_gpio_acc ? urs_pkg::URS_GPIO_POL : urs_pkg::URS_STOP1;
  assign enh7 = i_gpio_acc ? urs_pkg::URS_GPIO_SEL : urs_pkg::URS_STOP2;

  // read selection per address
  assign rd_tab[0] = enh ? urs_pkg::URS_FIFO_LVL :
                     div_bit ? (div_zero ? urs_pkg::URS_DEV_REV
                                         : urs_pkg::URS_DIV_LO)
                             : urs_pkg::URS_RX_HOLD;
  assign rd_tab[1] = enh ? urs_pkg::URS_FEAT_CTL :
                     div_bit ? urs_pkg::URS_DIV_HI
                             : urs_pkg::URS_INT_EN;
  assign rd_tab[2] = enh ? urs_pkg::URS_ENH_FN :
                     (div_acc & i_ext_feat) ? urs_pkg::URS_DIV_FRAC
                                            : urs_pkg::URS_INT_STAT;
  assign rd_tab[3] = urs_pkg::URS_LINE_CTL;
  assign rd_tab[4] = enh ? enh4 : urs_pkg::URS_MODEM_CTL;
  assign rd_tab[5] = enh ? enh5 : urs_pkg::URS_LINE_STAT;
  assign rd_tab[6] = enh ? enh6 : urs_pkg::URS_MODEM_STAT;
  assign rd_tab[7] = enh ? enh7 :
                     (i_gpio_acc | i_feat_sel) ? urs_pkg::URS_FIFO_LVL
                                               : urs_pkg::URS_SCRATCH;

  // write selection per address; read-only codes never appear here
  assign wr_tab[0] = enh ? urs_pkg::URS_TRIG_LVL :
                     div_bit ? urs_pkg::URS_DIV_LO
                             : urs_pkg::URS_TX_HOLD;
  assign wr_tab[1] = rd_tab[1];
  assign wr_tab[2] = enh ? urs_pkg::URS_ENH_FN :
                     (div_acc & i_ext_feat) ? urs_pkg::URS_DIV_FRAC
                                            : urs_pkg::URS_FIFO_CTL;
  assign wr_tab[3] = urs_pkg::URS_LINE_CTL;
  assign wr_tab[4] = rd_tab[4];
  assign wr_tab[5] = enh ? enh5 : urs_pkg::URS_RS485;
  assign wr_tab[6] = enh ? enh6 :
                     i_ext_feat ? urs_pkg::URS_SPEC_FN : urs_pkg::URS_NONE;
  assign wr_tab[7] = enh ? enh7 :
                     i_gpio_acc ? urs_pkg::URS_NONE :
                     i_feat_sel ? urs_pkg::URS_ENH_MODE
                                : urs_pkg::URS_SCRATCH;

  assign sel.rd_sel = rd_tab[i_addr];
  assign sel.wr_sel = wr_tab[i_addr];

endmodule // urs_decode

// ===== verilog/urs_pulse_reg.sv
`timescale 1ns/1ps
`include "urs_defs.svh"

module urs_pulse_reg (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_stb,
  input  wire logic [7:0] i_data,
  output logic            o_stb,
  output logic [7:0]      o_data
);

  // ----------------------------------------------------------------
  // strobe with data, one cycle late; data holds until next strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_stb  <= 1'b0;
      o_data <= `URS_RST_VAL;
    end else begin
      o_stb <= i_stb;
      if (i_stb) begin
        o_data <= i_data;
      end
    end
  end

endmodule // urs_pulse_reg

// ===== verilog/urs_register_select.sv
// Operation
// - address 0, divisor access, both divisor bytes zero: read gives device revision.
// - address 0, divisor bit set, not enhanced key: divisor low read/write.
// - address 1 under divisor access: divisor high read/write.
// - address 2 under divisor access with extended features: divisor fraction.
// - address 0, divisor bit clear: read receive holding, write transmit holding.
// - address 1 normally: interrupt enable read/write.
// - address 2: read interrupt status, write fifo control, per extended bit.
// - line control at address 3, modem control at address 4.
// - address 5: read line status; write rs485 setup outside enhanced set.
// - address 6: read modem status; write special function with extended bit.
// - address 7, gpio access clear: scratch pad, or by feature select bit write-only enhanced mode select; writes go nowhere with gpio access set.
// - fifo level count readable at 7 with feature select or gpio access set, at 0 in enhanced set.
// - address 0 in enhanced set: write fifo trigger level.
// - enhanced set: feature control at 1, enhanced function at 2.
// - enhanced set, gpio access clear: flow resume 1,2 then stop 1,2.
// - enhanced set, gpio access set: gpio interrupt, tristate, polarity, select.
`timescale 1ns/1ps
`include "urs_defs.svh"

module urs_register_select #(
  parameter logic [7:0] P_DEV_REV = `URS_DEV_REV_VAL // arbitrary value
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // host register port
  input  wire logic [2:0]  i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic             o_rd_valid,
  output logic [7:0]       o_rdata,
  // live status from the uart datapath
  input  wire logic [7:0]  i_rx_data,
  input  wire logic [7:0]  i_int_status,
  input  wire logic [7:0]  i_line_status,
  input  wire logic [7:0]  i_modem_status,
  input  wire logic [7:0]  i_fifo_level,
  // read side effects
  output logic             o_rx_pop,
  output logic             o_msr_rd,
  // write-only traffic toward the datapath
  output logic             o_tx_push,
  output logic [7:0]       o_tx_data,
  output logic             o_fifo_ctl_wr,
  output logic             o_trig_wr,
  output logic             o_spec_fn_wr,
  // stored configuration
  output logic [7:0]       o_divisor_low,
  output logic [7:0]       o_divisor_high,
  output logic [7:0]       o_divisor_fraction,
  output logic [7:0]       o_interrupt_enable,
  output logic [7:0]       o_fifo_control,
  output logic [7:0]       o_line_control,
  output logic [7:0]       o_modem_control,
  output logic [7:0]       o_rs485_setup,
  output logic [7:0]       o_special_function,
  output logic [7:0]       o_enh_mode_select,
  output logic [7:0]       o_trigger_level,
  output logic [7:0]       o_feature_control,
  output logic [7:0]       o_enhanced_function,
  output logic [31:0]      o_flow_chars,
  output logic [31:0]      o_gpio_cfg
);

  // ----------------------------------------------------------------
  // register code indices
  // ----------------------------------------------------------------
  localparam int IX_DEV_REV  = int'(urs_pkg::URS_DEV_REV);
  localparam int IX_DIV_LO   = int'(urs_pkg::URS_DIV_LO);
  localparam int IX_DIV_HI   = int'(urs_pkg::URS_DIV_HI);
  localparam int IX_DIV_FRAC = int'(urs_pkg::URS_DIV_FRAC);
  localparam int IX_RX_HOLD  = int'(urs_pkg::URS_RX_HOLD);
  localparam int IX_INT_EN   = int'(urs_pkg::URS_INT_EN);
  localparam int IX_INT_STAT = int'(urs_pkg::URS_INT_STAT);
  localparam int IX_FIFO_CTL = int'(urs_pkg::URS_FIFO_CTL);
  localparam int IX_LINE_CTL = int'(urs_pkg::URS_LINE_CTL);
  localparam int IX_MDM_CTL  = int'(urs_pkg::URS_MODEM_CTL);
  localparam int IX_LN_STAT  = int'(urs_pkg::URS_LINE_STAT);
  localparam int IX_RS485    = int'(urs_pkg::URS_RS485);
  localparam int IX_MDM_STAT = int'(urs_pkg::URS_MODEM_STAT);
  localparam int IX_SPEC_FN  = int'(urs_pkg::URS_SPEC_FN);
  localparam int IX_ENH_MODE = int'(urs_pkg::URS_ENH_MODE);
  localparam int IX_FIFO_LVL = int'(urs_pkg::URS_FIFO_LVL);
  localparam int IX_TRIG     = int'(urs_pkg::URS_TRIG_LVL);
  localparam int IX_FEAT_CTL = int'(urs_pkg::URS_FEAT_CTL);
  localparam int IX_ENH_FN   = int'(urs_pkg::URS_ENH_FN);
  localparam int IX_RESUME1  = int'(urs_pkg::URS_RESUME1);
  localparam int IX_GPIO_INT = int'(urs_pkg::URS_GPIO_INT);

  localparam logic [31:0] STORE_MASK = `URS_STORE_MASK;
  localparam logic [31:0] READ_MASK  = `URS_READ_MASK;

  // ----------------------------------------------------------------
  // register storage and decode
  // ----------------------------------------------------------------
  urs_pkg::urs_byte_type regs_r [32];
  urs_pkg::urs_byte_type rd_tab [32];

  urs_sel_if sel ();

  wire logic [4:0] rd_code = sel.rd_sel;
  wire logic [4:0] wr_code = sel.wr_sel;

  // the live line control value steers every selection but address 3, so a write to
  // it changes the map from the very next access onward
  urs_decode u_decode (
    .i_addr     (i_addr),
    .i_line_ctl (regs_r[IX_LINE_CTL]),
    .i_div_lo   (regs_r[IX_DIV_LO]),
    .i_div_hi   (regs_r[IX_DIV_HI]),
    .i_ext_feat (regs_r[IX_ENH_FN][`URS_EXT_FEAT_BIT]),
    .i_feat_sel (regs_r[IX_FEAT_CTL][`URS_FEAT_SEL_BIT]),
    .i_gpio_acc (regs_r[IX_SPEC_FN][`URS_GPIO_ACC_BIT]),
    .sel        (sel.dec)
  );

  // ----------------------------------------------------------------
  // per-code storage and read table
  // ----------------------------------------------------------------
  // one loop builds both: stored codes get a flop, live codes show the
  // datapath input, write-only and unmapped codes read as zero
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_reg
      wire logic hit_wr = i_wr & (wr_code == 5'(g));

      if (STORE_MASK[g]) begin : g_store
        always_ff @(posedge i_core_clk) begin
          if (!i_rst_b) begin
            regs_r[g] <= `URS_RST_VAL;
          end else if (hit_wr) begin
            regs_r[g] <= i_wdata;
          end
        end
      end else begin : g_nostore
        assign regs_r[g] = `URS_RST_VAL;
      end

      if (READ_MASK[g]) begin : g_rd_store
        assign rd_tab[g] = regs_r[g];
      end else if (g == IX_DEV_REV) begin : g_rd_rev
        assign rd_tab[g] = P_DEV_REV;
      end else if (g == IX_RX_HOLD) begin : g_rd_rx
        assign rd_tab[g] = i_rx_data;
      end else if (g == IX_INT_STAT) begin : g_rd_isr
        assign rd_tab[g] = i_int_status;
      end else if (g == IX_LN_STAT) begin : g_rd_lsr
        assign rd_tab[g] = i_line_status;
      end else if (g == IX_MDM_STAT) begin : g_rd_msr
        assign rd_tab[g] = i_modem_status;
      end else if (g == IX_FIFO_LVL) begin : g_rd_lvl
        assign rd_tab[g] = i_fifo_level;
      end else begin : g_rd_zero
        assign rd_tab[g] = `URS_ZERO_BYTE;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // the answer is sampled with the selection seen at the request edge,
  // so a write in the same cycle does not alter what is returned
  wire urs_pkg::urs_byte_type rd_val = rd_tab[rd_code];

  urs_pulse_reg u_rd_stage (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_stb      (i_rd),
    .i_data     (rd_val),
    .o_stb      (o_rd_valid),
    .o_data     (o_rdata)
  );

  // read side effects: popping the receive fifo, clearing modem deltas
  wire logic rx_pop_nxt  = i_rd & (rd_code == 5'(IX_RX_HOLD));
  wire logic msr_rd_nxt  = i_rd & (rd_code == 5'(IX_MDM_STAT));

  // ----------------------------------------------------------------
  // write-only traffic
  // ----------------------------------------------------------------
  wire logic tx_push_nxt = i_wr & (wr_code == 5'(int'(urs_pkg::URS_TX_HOLD)));
  wire logic fifo_wr_nxt = i_wr & (wr_code == 5'(IX_FIFO_CTL));
  wire logic trig_wr_nxt = i_wr & (wr_code == 5'(IX_TRIG));
  wire logic spec_wr_nxt = i_wr & (wr_code == 5'(IX_SPEC_FN));

  // transmit bytes are not kept here; the datapath takes them on the pulse
  urs_pulse_reg u_tx_stage (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_stb      (tx_push_nxt),
    .i_data     (i_wdata),
    .o_stb      (o_tx_push),
    .o_data     (o_tx_data)
  );

  // strobes line up with the stored value updating on the same edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_rx_pop      <= 1'b0;
      o_msr_rd      <= 1'b0;
      o_fifo_ctl_wr <= 1'b0;
      o_trig_wr     <= 1'b0;
      o_spec_fn_wr  <= 1'b0;
    end else begin
      o_rx_pop      <= rx_pop_nxt;
      o_msr_rd      <= msr_rd_nxt;
      o_fifo_ctl_wr <= fifo_wr_nxt;
      o_trig_wr     <= trig_wr_nxt;
      o_spec_fn_wr  <= spec_wr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs, straight from the storage flops
  // ----------------------------------------------------------------
  assign o_divisor_low       = regs_r[IX_DIV_LO];
  assign o_divisor_high      = regs_r[IX_DIV_HI];
  assign o_divisor_fraction  = regs_r[IX_DIV_FRAC];
  assign o_interrupt_enable  = regs_r[IX_INT_EN];
  assign o_fifo_control      = regs_r[IX_FIFO_CTL];
  assign o_line_control      = regs_r[IX_LINE_CTL];
  assign o_modem_control     = regs_r[IX_MDM_CTL];
  assign o_rs485_setup       = regs_r[IX_RS485];
  assign o_special_function  = regs_r[IX_SPEC_FN];
  assign o_enh_mode_select   = regs_r[IX_ENH_MODE];
  assign o_trigger_level     = regs_r[IX_TRIG];
  assign o_feature_control   = regs_r[IX_FEAT_CTL];
  assign o_enhanced_function = regs_r[IX_ENH_FN];

  // flow characters: resume 1 in the low byte up to stop 2 in the top
  assign o_flow_chars = {regs_r[IX_RESUME1 + 3], regs_r[IX_RESUME1 + 2],
                         regs_r[IX_RESUME1 + 1], regs_r[IX_RESUME1]};

  // gpio: interrupt enable low byte, then tristate, polarity, select
  assign o_gpio_cfg = {regs_r[IX_GPIO_INT + 3], regs_r[IX_GPIO_INT + 2],
                       regs_r[IX_GPIO_INT + 1], regs_r[IX_GPIO_INT]};

endmodule // urs_register_select

// ===== test/urs_select_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the register select block
// ----------------------------------------------------------------
module urs_select_monitor (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_rx_data,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_modem_status,
  input wire logic       o_rx_pop,
  input wire logic       o_msr_rd,
  input wire logic       o_tx_push,
  input wire logic [7:0] o_tx_data,
  input wire logic [7:0] o_line_control,
  input wire logic       o_trig_wr,
  input wire logic [7:0] o_trigger_level
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // decode qualifiers taken from the live line control value
  wire not_enh = (o_line_control != 8'hbf);
  wire div_on  = o_line_control[7];
  wire lc_wr   = i_wr && (i_addr == 3'h3);

  rd_answer_a: assert property (i_rd |=> o_rd_valid)
    else $error("read not answered");
  rd_quiet_a: assert property (!i_rd |=> !o_rd_valid)
    else $error("spurious read answer");
  tx_load_a: assert property (i_wr && i_addr == 3'h0 && !div_on
    |=> o_tx_push && o_tx_data == $past(i_wdata)) else $error("transmit load wrong");
  rx_read_a: assert property (i_rd && i_addr == 3'h0 && !div_on
    |=> o_rx_pop && o_rdata == $past(i_rx_data)) else $error("receive read wrong");
  lc_write_a: assert property (lc_wr |=> o_line_control == $past(i_wdata))
    else $error("line control not written");
  // a mid-run reset must not count as a stray change
  lc_hold_a: assert property (i_rst_b && !lc_wr |=> $stable(o_line_control))
    else $error("line control changed without write");
  ls_read_a: assert property (i_rd && i_addr == 3'h5 && not_enh
    |=> o_rdata == $past(i_line_status)) else $error("line status read wrong");
  msr_read_a: assert property (i_rd && i_addr == 3'h6 && not_enh
    |=> o_msr_rd && o_rdata == $past(i_modem_status)) else $error("modem status wrong");
  trig_load_a: assert property (i_wr && i_addr == 3'h0 && !not_enh
    |=> o_trig_wr && o_trigger_level == $past(i_wdata)) else $error("trigger load wrong");

  cov_enh_c: cover property (i_wr && !not_enh);
  cov_div_c: cover property (i_rd && div_on && not_enh);
  cov_rx_c:  cover property (o_rx_pop);
endmodule // urs_select_monitor

bind urs_register_select urs_select_monitor mon (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd),
  .i_wr(i_wr), .i_wdata(i_wdata), .o_rd_valid(o_rd_valid), .o_rdata(o_rdata),
  .i_rx_data(i_rx_data), .i_line_status(i_line_status),
  .i_modem_status(i_modem_status), .o_rx_pop(o_rx_pop), .o_msr_rd(o_msr_rd),
  .o_tx_push(o_tx_push), .o_tx_data(o_tx_data), .o_line_control(o_line_control),
  .o_trig_wr(o_trig_wr), .o_trigger_level(o_trigger_level));

// ===== test/urs_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module urs_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rdata,
  output logic [2:0]      o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic [7:0]      o_wdata
);
  initial begin
    o_addr  = 3'h0;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
  end

  // one-cycle write; released data shows the inverse so stale bytes never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wr    <= 1'b1;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask

  // one-cycle read, answer awaited for a bounded number of cycles
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    for (int n = 0; n < 3 && !ok; n++) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask
endmodule // urs_host_model

// ===== test/uart_register_select_map_bench.sv
`timescale 1ns/1ps

module uart_register_select_map_bench;
  localparam logic [7:0] rev_val = 8'h6e; // arbitrary value
  localparam logic [7:0] rx_val  = 8'h3c;
  localparam logic [7:0] is_val  = 8'hc1;
  localparam logic [7:0] ls_val  = 8'h60;
  localparam logic [7:0] ms_val  = 8'hb0;
  localparam logic [7:0] fl_val  = 8'h47;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  addr;
  logic        rd, wr, rd_valid, rx_pop, msr_rd, tx_push, fctl_wr, trig_wr, sfn_wr;
  logic [7:0]  wdata, rdata, tx_data, div_lo, div_hi, div_frac, fctl, rs485;
  logic [7:0]  sfn, enhanced_mode_select, trig, interrupt_enable, modem_control, feature_control, enhanced_function;
  logic [31:0] flow, gpio;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  urs_host_model host (.i_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata),
    .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  urs_register_select #(.P_DEV_REV(rev_val)) dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .o_rd_valid(rd_valid), .o_rdata(rdata), .i_rx_data(rx_val),
    .i_int_status(is_val), .i_line_status(ls_val), .i_modem_status(ms_val),
    .i_fifo_level(fl_val), .o_rx_pop(rx_pop), .o_msr_rd(msr_rd),
    .o_tx_push(tx_push), .o_tx_data(tx_data), .o_fifo_ctl_wr(fctl_wr),
    .o_trig_wr(trig_wr), .o_spec_fn_wr(sfn_wr), .o_divisor_low(div_lo),
    .o_divisor_high(div_hi), .o_divisor_fraction(div_frac), .o_interrupt_enable(interrupt_enable),
    .o_fifo_control(fctl), .o_line_control(), .o_modem_control(modem_control),
    .o_rs485_setup(rs485), .o_special_function(sfn), .o_enh_mode_select(enhanced_mode_select),
    .o_trigger_level(trig), .o_feature_control(feature_control), .o_enhanced_function(enhanced_function),
    .o_flow_chars(flow), .o_gpio_cfg(gpio));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // wide enough for the gpio and flow words side by side
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write, then step off the edge so one-cycle strobes can be looked at
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    host.wr(a, d);
    #1;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (!ok) begin
      n_fail++;
      finish_test();
    end else begin
      chk(d, e);
    end
  endtask

  // upper four addresses written then read back, bytes base+4..base+7
  task automatic fill_upper(input logic [7:0] base);
    for (int i = 4; i < 8; i++) wr_reg(i[2:0], base + i[7:0]);
    for (int i = 4; i < 8; i++) rd_chk(i[2:0], base + i[7:0]);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_std;
    wr_reg(3'h3, 8'h03); rd_chk(3'h3, 8'h03);
    wr_reg(3'h6, 8'h77); chk({sfn_wr, sfn}, 9'h000);
    wr_reg(3'h0, 8'ha5); chk({tx_push, tx_data}, 9'h1a5);
    rd_chk(3'h0, rx_val); chk(rx_pop, 1'b1);
    wr_reg(3'h1, 8'h0f); rd_chk(3'h1, 8'h0f); chk(interrupt_enable, 8'h0f);
    wr_reg(3'h4, 8'h1b); rd_chk(3'h4, 8'h1b); chk(modem_control, 8'h1b);
    wr_reg(3'h2, 8'hc7); chk({fctl_wr, fctl}, 9'h1c7);
    rd_chk(3'h2, is_val);
    wr_reg(3'h5, 8'h39); chk(rs485, 8'h39);
    rd_chk(3'h5, ls_val);
    rd_chk(3'h6, ms_val); chk(msr_rd, 1'b1);
    wr_reg(3'h7, 8'h5e); rd_chk(3'h7, 8'h5e);
  endtask

  task automatic t_div;
    wr_reg(3'h3, 8'h80); rd_chk(3'h0, rev_val);
    wr_reg(3'h0, 8'h12); rd_chk(3'h0, 8'h12); chk(div_lo, 8'h12);
    wr_reg(3'h1, 8'h34); rd_chk(3'h1, 8'h34); chk(div_hi, 8'h34);
    wr_reg(3'h2, 8'h56); chk({div_frac, fctl}, 16'h0056);
    rd_chk(3'h2, is_val);
  endtask

  task automatic t_enh;
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h0, 8'h2a); chk({trig_wr, trig}, 9'h12a);
    rd_chk(3'h0, fl_val);
    wr_reg(3'h1, 8'h25); rd_chk(3'h1, 8'h25); chk(feature_control, 8'h25);
    wr_reg(3'h2, 8'h10); rd_chk(3'h2, 8'h10); chk(enhanced_function, 8'h10);
    // the enhanced page must leave the standard modem control alone
    fill_upper(8'ha0); chk(flow, 32'ha7a6a5a4); chk(modem_control, 8'h1b);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h6, 8'h01); chk({sfn_wr, sfn}, 9'h101);
    rd_chk(3'h7, fl_val);
    wr_reg(3'h3, 8'hbf);
    fill_upper(8'hc0); chk({gpio, flow}, 64'hc7c6c5c4_a7a6a5a4);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h6, 8'h00);
  endtask

  task automatic t_ext;
    wr_reg(3'h3, 8'h80); wr_reg(3'h2, 8'h9d); chk(div_frac, 8'h9d);
    rd_chk(3'h2, 8'h9d);
    wr_reg(3'h3, 8'h03); rd_chk(3'h2, is_val);
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h1, 8'h40);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h7, 8'h9c); chk(enhanced_mode_select, 8'h9c);
    rd_chk(3'h7, fl_val);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_std();
    t_div();
    t_enh();
    t_ext();
    finish_test();
  end
endmodule // uart_register_select_map_bench
